//--- common/timer_pkg.sv
/*
 * shared constants for the dual legacy counter/timer: mode codes,
 * prescale encodings, divider ratios, reset values and pin indices.
 * assumes a single core clock domain; the timer, its prescaler and the test bench read this package.
 */
package timer_pkg;

    // per-unit operating mode, two select bits each
    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_8RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } mode_t;

    // prescale select encodings
    localparam logic [1:0] SCALE_SYS12 = 2'h0;
    localparam logic [1:0] SCALE_SYS4 = 2'h1;
    localparam logic [1:0] SCALE_SYS48 = 2'h2;
    localparam logic [1:0] SCALE_EXT8 = 2'h3;

    // divider ratios
    localparam logic [5:0] DIV_SYS12 = 6'h0C;
    localparam logic [5:0] DIV_SYS4 = 6'h04;
    localparam logic [5:0] DIV_SYS48 = 6'h30;
    localparam logic [5:0] DIV_EXT8 = 6'h08;
    localparam logic [5:0] DIV_RESET = 6'h00;

    // reset values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;

    // synchronised pin indices
    localparam int PIN_COUNT = 5;
    localparam int PIN_EVENT0 = 0;
    localparam int PIN_EVENT1 = 1;
    localparam int PIN_UNIT0_GATE_BIT = 2;
    localparam int PIN_GATE1 = 3;
    localparam int PIN_EXTCLK = 4;

endpackage : timer_pkg

//--- hw/legacy_dual_timer.sv
/*
 * two compatible counter/timers with 13-bit, 16-bit, 8-bit reload and
 * split modes, gated counting, prescaled timebase and overflow flags.
 * assumes software drives the configuration ports directly and loads
 * count bytes through the write strobes; pins are asynchronous.
 */
`timescale 1ns/1ps

// How it works
// - each synced falling edge on the event pin adds one in counter operation.
// - timebase is system clock, prescale /12, /4, /48, external /8, or pin.
// - each unit takes its own two mode-select bits.
// - 13-bit mode uses high byte plus low bits 4..0; bits 7..5 undefined.
// - 13-bit wrap to zero sets the unit flag and may request interrupt.
// - count select picks pin edges; else clock select picks system or prescaled.
// - gate bit clear counts on run; set also needs gate input at polarity.
// - setting run does not clear or reload the count.
// - unit 1 mirrors unit 0 in modes 0 to 2 with its own bits.
// - mode 1 equals mode 0 but counts the full sixteen bits.
// - mode 2 counts low byte, reloads from unchanged high byte on overflow.
// - split mode low byte is an 8-bit unit using unit 0 controls.
// - split mode high byte is a timer run by unit 1 run, sets flag 1.
// - with unit 0 split, unit 1 ignores pins, sets no flag, still pulses overflow.
// - with unit 0 split, unit 1 runs in modes 0 to 2, stops in mode 3.
// - each flag requests an interrupt only when its enable bit is set.
module legacy_dual_timer (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic eventPin0,
    input wire logic eventPin1,
    input wire logic gateInput0,
    input wire logic gateInput1,
    input wire logic extClkPin,
    input wire logic [1:0] modeSel0,
    input wire logic [1:0] modeSel1,
    input wire logic countSelect0,
    input wire logic countSelect1,
    input wire logic gateBit0,
    input wire logic gateBit1,
    input wire logic gate0Polarity,
    input wire logic gate1Polarity,
    input wire logic clockSelect0,
    input wire logic clockSelect1,
    input wire logic [1:0] prescaleSelect,
    input wire logic runBit0,
    input wire logic runBit1,
    input wire logic irqEnable0,
    input wire logic irqEnable1,
    input wire logic wrLow0,
    input wire logic wrHigh0,
    input wire logic wrLow1,
    input wire logic wrHigh1,
    input wire logic [7:0] wrData,
    input wire logic clearFlag0,
    input wire logic clearFlag1,
    output logic [7:0] unit0CountLow,
    output logic [7:0] unit0CountHigh,
    output logic [7:0] unit1CountLow,
    output logic [7:0] unit1CountHigh,
    output logic overflowFlag0,
    output logic overflowFlag1,
    output logic irqRequest0,
    output logic irqRequest1,
    output logic unit1OverflowPulse
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] low0_q;
    logic [7:0] high0_q;
    logic [7:0] low1_q;
    logic [7:0] high1_q;
    logic flag0_q;
    logic flag1_q;
    logic ovfPulse1_q;

    logic [timer_pkg::PIN_COUNT-1:0] pinRaw;
    logic [timer_pkg::PIN_COUNT-1:0] pinLevel;
    logic [timer_pkg::PIN_COUNT-1:0] pinFall;

    logic preTick;
    logic split0;
    logic gateOk0;
    logic gateOk1;
    logic timeBase0;
    logic timeBase1;
    logic tick0;
    logic tick1;
    logic tickHigh0;
    logic active1;
    logic [16:0] step0;
    logic [16:0] step1;
    logic ovf0;
    logic ovf1;
    logic ovfHigh0;

    ////////////////////////////////////////////////////////////////////
    // one count step: {overflow, high byte, low byte}

    function automatic logic [16:0] stepCount(
        input logic [1:0] mode,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        logic [12:0] c13;
        logic [15:0] c16;
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        case (mode)
            timer_pkg::MODE_13BIT: begin
                // upper low-byte bits are left as they were
                stepCount = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
            end
            timer_pkg::MODE_16BIT: begin
                stepCount = {&{hi, lo}, c16};
            end
            timer_pkg::MODE_8RELOAD: begin
                if (&lo) begin
                    stepCount = {1'b1, hi, hi};
                end else begin
                    stepCount = {1'b0, hi, c16[7:0]};
                end
            end
            default: begin
                // split low byte: plain 8-bit wrap
                stepCount = {&lo, hi, c16[7:0]};
            end
        endcase
    endfunction : stepCount

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and prescaler

    assign pinRaw[timer_pkg::PIN_EVENT0] = eventPin0;
    assign pinRaw[timer_pkg::PIN_EVENT1] = eventPin1;
    assign pinRaw[timer_pkg::PIN_UNIT0_GATE_BIT] = gateInput0;
    assign pinRaw[timer_pkg::PIN_GATE1] = gateInput1;
    assign pinRaw[timer_pkg::PIN_EXTCLK] = extClkPin;

    generate
        for (genvar i = 0; i < timer_pkg::PIN_COUNT; i++) begin : g_pin
            pin_sync_edge u_sync (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .pinIn(pinRaw[i]),
                .level(pinLevel[i]),
                .fall(pinFall[i])
            );
        end
    endgenerate

    timebase_prescaler u_prescale (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .scaleSel(prescaleSelect),
        .extFall(pinFall[timer_pkg::PIN_EXTCLK]),
        .tick(preTick)
    );

    ////////////////////////////////////////////////////////////////////
    // count qualification

    assign split0 = (modeSel0 == timer_pkg::MODE_SPLIT);

    // gate input must sit at the polarity level when gating is on
    assign gateOk0 = !gateBit0 || (pinLevel[timer_pkg::PIN_UNIT0_GATE_BIT] == gate0Polarity);
    assign gateOk1 = !gateBit1 || (pinLevel[timer_pkg::PIN_GATE1] == gate1Polarity);

    // internal timebases: system clock or prescaled tick
    assign timeBase0 = clockSelect0 ? 1'b1 : preTick;
    assign timeBase1 = clockSelect1 ? 1'b1 : preTick;

    assign tick0 = runBit0 && gateOk0
        && (countSelect0 ? pinFall[timer_pkg::PIN_EVENT0] : timeBase0);

    // split high byte: timer only, unit 0 timebase, unit 1 run bit
    assign tickHigh0 = split0 && runBit1 && timeBase0;

    // unit 1 is run by its mode alone while unit 0 is split
    always_comb begin
        if (modeSel1 == timer_pkg::MODE_SPLIT) begin
            active1 = 1'b0;
        end else if (split0) begin
            active1 = 1'b1;
        end else begin
            active1 = runBit1 && gateOk1;
        end
    end

    // pins never clock unit 1 while unit 0 is split
    assign tick1 = active1
        && ((countSelect1 && !split0) ? pinFall[timer_pkg::PIN_EVENT1] : timeBase1);

    assign step0 = stepCount(modeSel0, high0_q, low0_q);
    assign step1 = stepCount(modeSel1, high1_q, low1_q);

    assign ovf0 = tick0 && step0[16] && !wrLow0 && !wrHigh0;
    assign ovf1 = tick1 && step1[16] && !wrLow1 && !wrHigh1;
    assign ovfHigh0 = tickHigh0 && (&high0_q) && !wrHigh0;

    ////////////////////////////////////////////////////////////////////
    // unit 0 count bytes; a software write wins over a count step

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            low0_q <= timer_pkg::COUNT_RESET;
        end else if (wrLow0) begin
            low0_q <= wrData;
        end else if (wrHigh0) begin
            low0_q <= low0_q;
        end else if (tick0) begin
            low0_q <= step0[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            high0_q <= timer_pkg::COUNT_RESET;
        end else if (wrHigh0) begin
            high0_q <= wrData;
        end else if (split0) begin
            if (tickHigh0) begin
                high0_q <= high0_q + 8'h01;
            end
        end else if (tick0 && !wrLow0) begin
            high0_q <= step0[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // unit 1 count bytes

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            low1_q <= timer_pkg::COUNT_RESET;
        end else if (wrLow1) begin
            low1_q <= wrData;
        end else if (tick1 && !wrHigh1) begin
            low1_q <= step1[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            high1_q <= timer_pkg::COUNT_RESET;
        end else if (wrHigh1) begin
            high1_q <= wrData;
        end else if (tick1 && !wrLow1) begin
            high1_q <= step1[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // overflow flags: set wins over clear, sticky otherwise

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flag0_q <= timer_pkg::FLAG_RESET;
        end else if (ovf0) begin
            flag0_q <= 1'b1;
        end else if (clearFlag0) begin
            flag0_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flag1_q <= timer_pkg::FLAG_RESET;
        end else if (ovfHigh0 || (ovf1 && !split0)) begin
            flag1_q <= 1'b1;
        end else if (clearFlag1) begin
            flag1_q <= 1'b0;
        end
    end

    // unit 1 overflow keeps feeding baud-rate and converter triggers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ovfPulse1_q <= 1'b0;
        end else begin
            ovfPulse1_q <= ovf1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign unit0CountLow = low0_q;
    assign unit0CountHigh = high0_q;
    assign unit1CountLow = low1_q;
    assign unit1CountHigh = high1_q;
    assign overflowFlag0 = flag0_q;
    assign overflowFlag1 = flag1_q;
    assign irqRequest0 = flag0_q && irqEnable0;
    assign irqRequest1 = flag1_q && irqEnable1;
    assign unit1OverflowPulse = ovfPulse1_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence evFall0Seq;
        pinLevel[timer_pkg::PIN_EVENT0] ##1 !pinLevel[timer_pkg::PIN_EVENT0];
    endsequence

    sequence countCfg0Seq;
        runBit0 && !gateBit0 && countSelect0 && !wrLow0 && !wrHigh0
            && modeSel0 == timer_pkg::MODE_16BIT;
    endsequence

    a_edge_counts: assert property (@(posedge core_clk) disable iff (!rst_b)
        (evFall0Seq ##0 countCfg0Seq) |=> {high0_q, low0_q} == $past({high0_q, low0_q}) + 16'h0001)
        else $error("event pin fall did not add one");

    a_flag0_on_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tick0 && modeSel0 == timer_pkg::MODE_13BIT && (&{high0_q, low0_q[4:0]})
            && !wrLow0 && !wrHigh0) |=> (flag0_q && high0_q == 8'h00 && low0_q[4:0] == 5'h00))
        else $error("13-bit wrap did not clear count and set flag");

    a_reload_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tick0 && modeSel0 == timer_pkg::MODE_8RELOAD && (&low0_q) && !wrLow0 && !wrHigh0)
            |=> (low0_q == $past(high0_q) && $stable(high0_q) && flag0_q))
        else $error("mode 2 reload wrong");

    a_stop_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!runBit0 && !wrLow0 && !wrHigh0 && !split0) |=> $stable({high0_q, low0_q}))
        else $error("unit 0 counted while stopped");

    a_split_high_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        (split0 && tickHigh0 && (&high0_q) && !wrHigh0) |=> (flag1_q && high0_q == 8'h00))
        else $error("split high overflow did not set flag 1");

    a_unit1_no_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        (split0 && !ovfHigh0 && !flag1_q) |=> !flag1_q)
        else $error("unit 1 set its flag while unit 0 split");

    a_unit1_parked: assert property (@(posedge core_clk) disable iff (!rst_b)
        (modeSel1 == timer_pkg::MODE_SPLIT && !wrLow1 && !wrHigh1) |=> $stable({high1_q, low1_q}))
        else $error("unit 1 counted in mode 3");

    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
        (flag0_q && !clearFlag0) |=> flag0_q [*1] ##0 (irqRequest0 == irqEnable0))
        else $error("flag 0 dropped without clear");

    a_irq_needs_en: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ovf1 && !split0 && irqEnable1) |=> irqRequest1)
        else $error("enabled unit 1 overflow gave no request");

endmodule : legacy_dual_timer

//--- hw/pin_sync_edge.sv
/*
 * two-stage synchroniser for one asynchronous pin, with falling edge
 * detection on the synchronised level.
 * assumes the pin holds each level for at least two core clock periods.
 */
`timescale 1ns/1ps
module pin_sync_edge (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic pinIn,
    output logic level,
    output logic fall
);
    logic stage1_q;
    logic stage2_q;
    logic last_q;

    // stage1_q is read only by stage2_q
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stage1_q <= 1'b1;
            stage2_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            stage1_q <= pinIn;
            stage2_q <= stage1_q;
            last_q <= stage2_q;
        end
    end

    assign level = stage2_q;
    assign fall = last_q & ~stage2_q;

    a_sync_fall_delay: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pinIn ##1 !pinIn) |-> ##2 fall)
        else $error("falling pin not seen three cycles later");

endmodule : pin_sync_edge

//--- hw/timebase_prescaler.sv
/*
 * prescaled timebase: one-cycle tick every 12, 4 or 48 core clocks,
 * or every 8 falling edges of the synchronised external clock.
 * assumes extFall is already synchronised to core_clk.
 */
`timescale 1ns/1ps
module timebase_prescaler (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [1:0] scaleSel,
    input wire logic extFall,
    output logic tick
);
    logic [5:0] divCnt_q;
    logic [1:0] lastSel_q;
    logic [5:0] limit;
    logic step;

    always_comb begin
        case (scaleSel)
            timer_pkg::SCALE_SYS12: limit = timer_pkg::DIV_SYS12;
            timer_pkg::SCALE_SYS4: limit = timer_pkg::DIV_SYS4;
            timer_pkg::SCALE_SYS48: limit = timer_pkg::DIV_SYS48;
            default: limit = timer_pkg::DIV_EXT8;
        endcase
    end

    assign step = (scaleSel == timer_pkg::SCALE_EXT8) ? extFall : 1'b1;
    assign tick = step && (divCnt_q == limit - 6'h01) && (lastSel_q == scaleSel);

    // restart the division whenever the scale changes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            divCnt_q <= timer_pkg::DIV_RESET;
            lastSel_q <= timer_pkg::SCALE_SYS12;
        end else begin
            lastSel_q <= scaleSel;
            if (lastSel_q != scaleSel || tick) begin
                divCnt_q <= timer_pkg::DIV_RESET;
            end else if (step) begin
                divCnt_q <= divCnt_q + 6'h01;
            end
        end
    end

    a_prescale_gap: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tick && scaleSel == timer_pkg::SCALE_SYS4) |=> !tick [*3])
        else $error("prescaled tick closer than four cycles");

endmodule : timebase_prescaler

//--- tb/event_source_model.sv
/*
 * behavioural driver of the event count pins and gate input pins.
 * assumes the bench calls its tasks from one process; pins move only at falling edges.
 */
`timescale 1ns/1ps
module event_source_model (
    input wire logic core_clk,
    output logic eventPin0,
    output logic eventPin1,
    output logic gateInput0,
    output logic gateInput1
);
    initial begin
        eventPin0 = 1'b1;
        eventPin1 = 1'b1;
        gateInput0 = 1'b0;
        gateInput1 = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // n falling edges, each level held for hold whole clock periods, at least two
    task automatic pulses(input int unit, input int n, input int hold);
        int h;
        h = (hold < 2) ? 2 : hold;
        repeat (n) begin
            @(negedge core_clk);
            if (unit == 0) eventPin0 = 1'b0;
            else eventPin1 = 1'b0;
            repeat (h) @(negedge core_clk);
            if (unit == 0) eventPin0 = 1'b1;
            else eventPin1 = 1'b1;
            repeat (h - 1) @(negedge core_clk);
        end
    endtask : pulses

    task automatic set_gate(input int unit, input logic level);
        @(negedge core_clk);
        if (unit == 0) gateInput0 = level;
        else gateInput1 = level;
        repeat (4) @(negedge core_clk);
    endtask : set_gate
endmodule : event_source_model

//--- tb/legacy_dual_timer_test.sv
/*
 * self-checking bench for the dual counter/timer: byte writes, all modes,
 * gating, timebases, event counting and split operation.
 * assumes event_source_model drives the event and gate pins.
 */
`timescale 1ns/1ps
module legacy_dual_timer_test;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic eventPin0, eventPin1, gateInput0, gateInput1;
    logic extClkPin = 1'b1;
    logic [1:0] modeSel0 = 2'h1, modeSel1 = 2'h3, prescaleSelect = 2'h0;
    logic countSelect0 = 1'b0, countSelect1 = 1'b0, gateBit0 = 1'b0, gateBit1 = 1'b0;
    logic gate0Polarity = 1'b1, gate1Polarity = 1'b1, clockSelect0 = 1'b1, clockSelect1 = 1'b1;
    logic runBit0 = 1'b0, runBit1 = 1'b0, irqEnable0 = 1'b0, irqEnable1 = 1'b0;
    logic wrLow0 = 1'b0, wrHigh0 = 1'b0, wrLow1 = 1'b0, wrHigh1 = 1'b0;
    logic [7:0] wrData = 8'h00;
    logic clearFlag0 = 1'b0, clearFlag1 = 1'b0;
    logic [7:0] unit0CountLow, unit0CountHigh, unit1CountLow, unit1CountHigh;
    logic overflowFlag0, overflowFlag1, irqRequest0, irqRequest1, unit1OverflowPulse;
    int errors = 0;
    int checksDone = 0;
    int cycles = 0;
    int pulseCount = 0;
    int pulseBase = 0;
    logic [5:0] divs [4];

    always #25 core_clk = ~core_clk;

    legacy_dual_timer legacy_dual_timer_i (.core_clk(core_clk), .rst_b(rst_b), .eventPin0(eventPin0),
        .eventPin1(eventPin1), .gateInput0(gateInput0), .gateInput1(gateInput1), .extClkPin(extClkPin),
        .modeSel0(modeSel0), .modeSel1(modeSel1), .countSelect0(countSelect0), .countSelect1(countSelect1),
        .gateBit0(gateBit0), .gateBit1(gateBit1), .gate0Polarity(gate0Polarity),
        .gate1Polarity(gate1Polarity), .clockSelect0(clockSelect0), .clockSelect1(clockSelect1),
        .prescaleSelect(prescaleSelect), .runBit0(runBit0), .runBit1(runBit1), .irqEnable0(irqEnable0),
        .irqEnable1(irqEnable1), .wrLow0(wrLow0), .wrHigh0(wrHigh0), .wrLow1(wrLow1), .wrHigh1(wrHigh1),
        .wrData(wrData), .clearFlag0(clearFlag0), .clearFlag1(clearFlag1), .unit0CountLow(unit0CountLow),
        .unit0CountHigh(unit0CountHigh), .unit1CountLow(unit1CountLow), .unit1CountHigh(unit1CountHigh),
        .overflowFlag0(overflowFlag0), .overflowFlag1(overflowFlag1), .irqRequest0(irqRequest0),
        .irqRequest1(irqRequest1), .unit1OverflowPulse(unit1OverflowPulse));

    event_source_model event_source_model_i (.core_clk(core_clk), .eventPin0(eventPin0),
        .eventPin1(eventPin1), .gateInput0(gateInput0), .gateInput1(gateInput1));

    ////////////////////////////////////////////////////////////////////////////
    // external clock: 2 cycles high, 2 low, free running
    always @(negedge core_clk) begin
        if (cycles % 2 == 0) extClkPin <= ~extClkPin;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (unit1OverflowPulse === 1'b1) pulseCount <= pulseCount + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            $display("unexpected at %0t: run did not finish in time", $time);
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone = checksDone + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // which: 0 low0, 1 high0, 2 low1, 3 high1
    task automatic wr(input int which, input logic [7:0] d);
        @(negedge core_clk);
        wrData = d;
        wrLow0 = (which == 0);
        wrHigh0 = (which == 1);
        wrLow1 = (which == 2);
        wrHigh1 = (which == 3);
        @(negedge core_clk);
        {wrLow0, wrHigh0, wrLow1, wrHigh1} = 4'h0;
    endtask : wr

    // run bit high for exactly n rising edges
    task automatic run(input int unit, input int n);
        @(negedge core_clk);
        if (unit == 0) runBit0 = 1'b1;
        else runBit1 = 1'b1;
        repeat (n) @(negedge core_clk);
        runBit0 = 1'b0;
        runBit1 = 1'b0;
        @(negedge core_clk);
    endtask : run

    task automatic clear_flags();
        @(negedge core_clk);
        clearFlag0 = 1'b1;
        clearFlag1 = 1'b1;
        @(negedge core_clk);
        clearFlag0 = 1'b0;
        clearFlag1 = 1'b0;
        @(negedge core_clk);
    endtask : clear_flags

    task automatic results();
        $display("checks %0d, mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        divs = '{timer_pkg::DIV_SYS12, timer_pkg::DIV_SYS4, timer_pkg::DIV_SYS48, timer_pkg::DIV_EXT8};
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        check({unit0CountHigh, unit0CountLow}, 16'h0000);
        check({overflowFlag0, overflowFlag1, irqRequest0, irqRequest1}, 16'h0000);
        // 16-bit wrap, flag and interrupt forwarding
        irqEnable0 = 1'b1;
        wr(0, 8'hFE);
        wr(1, 8'hFF);
        check({unit0CountHigh, unit0CountLow}, 16'hFFFE);
        run(0, 3);
        check({unit0CountHigh, unit0CountLow}, 16'h0001);
        check({overflowFlag0, irqRequest0}, 16'h0003);
        irqEnable0 = 1'b0;
        @(negedge core_clk);
        check({overflowFlag0, irqRequest0}, 16'h0002);
        clear_flags();
        check(overflowFlag0, 1'b0);
        // 13-bit wrap: low bits 4..0 only
        modeSel0 = timer_pkg::MODE_13BIT;
        wr(0, 8'h1E);
        wr(1, 8'hFF);
        run(0, 1);
        check({unit0CountHigh, unit0CountLow[4:0], overflowFlag0}, 32'h00003FFE);
        run(0, 1);
        check({unit0CountHigh, unit0CountLow[4:0], overflowFlag0}, 16'h0001);
        clear_flags();
        // 8-bit reload
        modeSel0 = timer_pkg::MODE_8RELOAD;
        wr(0, 8'hFF);
        wr(1, 8'hA0);
        run(0, 2);
        check({unit0CountHigh, unit0CountLow, 7'h00, overflowFlag0}, 32'h00A0A101);
        clear_flags();
        // prescaled timebases: a window of four periods holds four ticks
        modeSel0 = timer_pkg::MODE_16BIT;
        clockSelect0 = 1'b0;
        for (int s = 0; s < 4; s++) begin
            prescaleSelect = s[1:0];
            wr(0, 8'h00);
            wr(1, 8'h00);
            repeat (60) @(negedge core_clk);
            run(0, 4 * int'(divs[s]) * ((s == 3) ? 4 : 1));
            check({unit0CountHigh, unit0CountLow}, 16'h0004);
        end
        clockSelect0 = 1'b1;
        // gate with both polarities
        gateBit0 = 1'b1;
        for (int p = 0; p < 2; p++) begin
            gate0Polarity = p[0];
            wr(0, 8'h00);
            event_source_model_i.set_gate(0, ~p[0]);
            run(0, 8);
            check(unit0CountLow, 8'h00);
            event_source_model_i.set_gate(0, p[0]);
            run(0, 8);
            check(unit0CountLow, 8'h08);
        end
        gateBit0 = 1'b0;
        // event counting on unit 0
        countSelect0 = 1'b1;
        wr(0, 8'h00);
        runBit0 = 1'b1;
        event_source_model_i.pulses(0, 5, 2);
        repeat (6) @(negedge core_clk);
        runBit0 = 1'b0;
        check(unit0CountLow, 8'h05);
        countSelect0 = 1'b0;
        // unit 1 in reload mode counting its pin
        modeSel1 = timer_pkg::MODE_8RELOAD;
        countSelect1 = 1'b1;
        wr(2, 8'hFD);
        wr(3, 8'h30);
        irqEnable1 = 1'b1;
        runBit1 = 1'b1;
        event_source_model_i.pulses(1, 4, 3);
        repeat (6) @(negedge core_clk);
        runBit1 = 1'b0;
        check({unit1CountHigh, unit1CountLow, 7'h00, overflowFlag1}, 32'h00303101);
        check(irqRequest1, 1'b1);
        countSelect1 = 1'b0;
        clear_flags();
        // unit 1 gated timer: a closed gate holds the count
        gateBit1 = 1'b1;
        wr(3, 8'h00);
        wr(2, 8'h00);
        run(1, 6);
        check(unit1CountLow, 8'h00);
        event_source_model_i.set_gate(1, 1'b1);
        run(1, 6);
        check(unit1CountLow, 8'h06);
        gateBit1 = 1'b0;
        // split mode: unit 1 idle in mode 3, free running in mode 1 without flag
        modeSel0 = timer_pkg::MODE_SPLIT;
        modeSel1 = timer_pkg::MODE_SPLIT;
        wr(2, 8'hFE);
        wr(3, 8'hFF);
        repeat (5) @(negedge core_clk);
        check({unit1CountHigh, unit1CountLow}, 16'hFFFE);
        pulseBase = pulseCount;
        // counter select is set, but the idle pin must not stall unit 1
        countSelect1 = 1'b1;
        modeSel1 = timer_pkg::MODE_16BIT;
        repeat (3) @(negedge core_clk);
        modeSel1 = timer_pkg::MODE_SPLIT;
        countSelect1 = 1'b0;
        repeat (3) @(negedge core_clk);
        check({unit1CountHigh, unit1CountLow}, 16'h0001);
        check(pulseCount - pulseBase, 32'h00000001);
        check(overflowFlag1, 1'b0);
        // split low byte on unit 0 controls, high byte on unit 1 run
        irqEnable1 = 1'b1;
        wr(0, 8'hFE);
        wr(1, 8'hFE);
        run(0, 2);
        check({unit0CountHigh, unit0CountLow, 6'h00, overflowFlag0, overflowFlag1}, 32'h00FE0002);
        clear_flags();
        run(1, 2);
        check({unit0CountHigh, unit0CountLow, 6'h00, overflowFlag0, overflowFlag1}, 32'h00000001);
        check(irqRequest1, 1'b1);
        results();
    end
endmodule : legacy_dual_timer_test
